// file: sdram_burst_pkg.sv
package sdram_burst_pkg;
   // ----------------------------------------
   // sizes
   // ----------------------------------------
   localparam int COL_W = 9;
   localparam int ROW_W = 12;
   localparam int BANK_W = 2;
   localparam int NUM_BANKS = 4;
   localparam int MODE_W = 12;
   localparam int REG_AW = 4;
   localparam int REG_DW = 32;
   localparam int PIN_W = 18;

   // ----------------------------------------
   // mode register layout
   // ----------------------------------------
   localparam int MR_BL_LSB = 0;
   localparam int MR_BL_W = 3;
   localparam int MR_ORDER_BIT = 3;
   localparam int MR_LAT_LSB = 4;
   localparam int MR_LAT_W = 3;
   localparam int MR_OPM_LOW = 7;
   localparam int MR_OPM_HIGH = 8;
   localparam int MR_WSA_BIT = 9;
   localparam logic [MODE_W-1:0] MODE_RESET = 12'h000;
   localparam logic [2:0] BL_CODE_1 = 3'h0;
   localparam logic [2:0] BL_CODE_2 = 3'h1;
   localparam logic [2:0] BL_CODE_4 = 3'h2;
   localparam logic [2:0] BL_CODE_8 = 3'h3;
   localparam logic [2:0] BL_CODE_FULL = 3'h7;
   localparam logic [2:0] LAT_CODE_2 = 3'h2;
   localparam logic [COL_W-1:0] MASK_1 = 9'h000;
   localparam logic [COL_W-1:0] MASK_2 = 9'h001;
   localparam logic [COL_W-1:0] MASK_4 = 9'h003;
   localparam logic [COL_W-1:0] MASK_8 = 9'h007;
   localparam logic [COL_W-1:0] MASK_PAGE = 9'h1ff;
   localparam int AP_BIT = 10;

   // ----------------------------------------
   // register port map
   // ----------------------------------------
   localparam logic [REG_AW-1:0] REG_MODE = 4'h0;
   localparam logic [REG_AW-1:0] REG_BANKS = 4'h4;
   localparam logic [REG_AW-1:0] REG_BURST = 4'h8;
   localparam int STAT_ACTIVE_BIT = 4;
   localparam int STAT_BANK_LSB = 16;

   // ----------------------------------------
   // command decode
   // ----------------------------------------
   typedef enum logic [2:0] {
      CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE, CMD_PRECHARGE,
      CMD_TERMINATE, CMD_LOAD_MODE, CMD_REFRESH
   } cmd_e;

   function automatic cmd_e cmd_decode(input logic cs_n, ras_n, cas_n, we_n);
      if (cs_n) return CMD_NOP;
      case ({ras_n, cas_n, we_n})
         3'h3: return CMD_ACTIVE;
         3'h5: return CMD_READ;
         3'h4: return CMD_WRITE;
         3'h2: return CMD_PRECHARGE;
         3'h6: return CMD_TERMINATE;
         3'h0: return CMD_LOAD_MODE;
         3'h1: return CMD_REFRESH;
         default: return CMD_NOP;
      endcase
   endfunction : cmd_decode
endpackage : sdram_burst_pkg

// file: sdram_ctrl_model.sv
`timescale 1ns/1ps
module sdram_ctrl_model
   import sdram_burst_pkg::*;
(
   // clock
   input wire logic clk_sys,
   // command pins toward the memory
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic [BANK_W-1:0] bank_select_lines,
   output logic [ROW_W-1:0] addr
);
   // deselected at time zero
   initial begin
      cs_n = 1'h1;
      {ras_n, cas_n, we_n} = 3'h7;
      bank_select_lines = 2'h0;
      addr = 12'h000;
   end

   // ----------------------------------------
   // one command: held through its edge, then released
   // ----------------------------------------
   // bench only opens rows after precharge and only loads mode with banks idle
   // 20 MHz is below every latency limit, so either latency is legal
   // full page is always ended by a terminate from the bench
   task automatic issue(input logic [2:0] rcw, input logic [1:0] bank, input logic [11:0] a);
      @(posedge clk_sys);
      cs_n <= 1'h0;
      {ras_n, cas_n, we_n} <= rcw;
      bank_select_lines <= bank;
      addr <= a;
      @(posedge clk_sys);
      cs_n <= 1'h1;
      {ras_n, cas_n, we_n} <= 3'h7;
      bank_select_lines <= ~bank; // released lines show no stale value
      addr <= ~a;
      // spacing after activate and mode load
      if (rcw == 3'h3 || rcw == 3'h0) repeat (3) @(posedge clk_sys);
   endtask : issue
endmodule : sdram_ctrl_model

// file: sdram_mode_burst_activate.sv
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
module sdram_mode_burst_activate
   import sdram_burst_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // command pins from the controller
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [BANK_W-1:0] bank_select_lines,
   input wire logic [ROW_W-1:0] addr,
   // register port
   input wire logic [REG_AW-1:0] reg_addr,
   input wire logic [REG_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [REG_DW-1:0] reg_rdata,
   // array access stream
   output logic access_valid,
   output logic access_write,
   output logic [BANK_W-1:0] access_bank,
   output logic [ROW_W-1:0] access_row,
   output logic [COL_W-1:0] access_col,
   // read data timing
   output logic dq_drive_en,
   output logic dq_data_valid,
   output logic [COL_W-1:0] dq_col,
   // status
   output logic mode_normal
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // column of beat idx inside the block picked by mask
   function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start,
         input logic [COL_W-1:0] idx, input logic [COL_W-1:0] mask, input logic il);
      logic [COL_W-1:0] off;
      off = il ? (start ^ idx) : COL_W'(start + idx);
      return (start & ~mask) | (off & mask);
   endfunction : burst_col

   // offset mask from burst code; reserved codes act as single access
   function automatic logic [COL_W-1:0] len_mask(input logic [2:0] code, input logic single);
      if (single) return MASK_1;
      case (code)
         BL_CODE_2: return MASK_2;
         BL_CODE_4: return MASK_4;
         BL_CODE_8: return MASK_8;
         BL_CODE_FULL: return MASK_PAGE;
         default: return MASK_1;
      endcase
   endfunction : len_mask

   // ----------------------------------------
   // pin synchroniser
   // ----------------------------------------
   logic [PIN_W-1:0] pin_meta;
   logic [PIN_W-1:0] pin_sync;

   // two stages, only the second is decoded
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pin_meta <= {1'b1, 3'h7, 14'h0000};
         pin_sync <= {1'b1, 3'h7, 14'h0000};
      end else begin
         pin_meta <= {cs_n, ras_n, cas_n, we_n, bank_select_lines, addr};
         pin_sync <= pin_meta;
      end
   end

   cmd_e cmd;
   logic [BANK_W-1:0] cmd_bank;
   logic [ROW_W-1:0] cmd_addr;
   assign cmd = cmd_decode(pin_sync[17], pin_sync[16], pin_sync[15], pin_sync[14]);
   assign cmd_bank = pin_sync[13:12];
   assign cmd_addr = pin_sync[11:0];

   // ----------------------------------------
   // mode register
   // ----------------------------------------
   logic [MODE_W-1:0] mode;
   logic [2:0] bl_code;
   logic order_il;
   logic lat3;
   logic wr_single;
   assign bl_code = mode[MR_BL_LSB +: MR_BL_W];
   assign order_il = mode[MR_ORDER_BIT];
   assign lat3 = mode[MR_LAT_LSB +: MR_LAT_W] != LAT_CODE_2;
   assign wr_single = mode[MR_WSA_BIT];
   assign mode_normal = !mode[MR_OPM_LOW] && !mode[MR_OPM_HIGH];

   // a pin load wins over a same-cycle software write
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         mode <= MODE_RESET;
      end else if (cmd == CMD_LOAD_MODE) begin
         mode <= cmd_addr;
      end else if (reg_wr && reg_addr == REG_MODE) begin
         mode <= reg_wdata[MODE_W-1:0];
      end
   end

   // ----------------------------------------
   // bank and row tracking
   // ----------------------------------------
   logic [NUM_BANKS-1:0] bank_open;
   logic [ROW_W-1:0] bank_row [NUM_BANKS];

   // activate records the row, precharge closes one bank or all
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         bank_open <= '0;
         for (int b = 0; b < NUM_BANKS; b++) begin
            bank_row[b] <= '0;
         end
      end else if (cmd == CMD_ACTIVE) begin
         bank_open[cmd_bank] <= 1'b1;
         bank_row[cmd_bank] <= cmd_addr;
      end else if (cmd == CMD_PRECHARGE) begin
         if (cmd_addr[AP_BIT]) begin
            bank_open <= '0;
         end else begin
            bank_open[cmd_bank] <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // burst address generator
   // ----------------------------------------
   logic col_go;
   logic col_wr;
   logic [COL_W-1:0] go_mask;
   logic burst_active;
   logic burst_il;
   logic burst_full;
   logic [COL_W-1:0] burst_start;
   logic [COL_W-1:0] burst_mask;
   logic [COL_W-1:0] burst_idx;
   logic acc_first;

   // column commands need normal mode and an open row; others are dropped
   assign col_go = (cmd == CMD_READ || cmd == CMD_WRITE) && mode_normal
                   && bank_open[cmd_bank];
   assign col_wr = cmd == CMD_WRITE;
   assign go_mask = len_mask(bl_code, col_wr && wr_single);

   // a new column command truncates any burst in flight
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         burst_active <= 1'b0;
         burst_il <= 1'b0;
         burst_full <= 1'b0;
         burst_start <= '0;
         burst_mask <= '0;
         burst_idx <= '0;
         access_valid <= 1'b0;
         access_write <= 1'b0;
         access_bank <= '0;
         access_row <= '0;
         access_col <= '0;
         acc_first <= 1'b0;
      end else if (col_go) begin
         burst_start <= cmd_addr[COL_W-1:0];
         burst_mask <= go_mask;
         burst_full <= go_mask == MASK_PAGE;
         burst_il <= order_il && go_mask != MASK_PAGE;
         burst_idx <= 9'h001;
         burst_active <= go_mask != MASK_1;
         access_valid <= 1'b1;
         access_write <= col_wr;
         access_bank <= cmd_bank;
         access_row <= bank_row[cmd_bank];
         access_col <= cmd_addr[COL_W-1:0];
         acc_first <= 1'b1;
      end else if (burst_active && cmd != CMD_TERMINATE && !(cmd == CMD_PRECHARGE
                   && (cmd_addr[AP_BIT] || cmd_bank == access_bank))) begin
         access_col <= burst_col(burst_start, burst_idx, burst_mask,
               burst_il);
         burst_idx <= COL_W'(burst_idx + 9'h001);
         burst_active <= burst_full || burst_idx != burst_mask;
         acc_first <= 1'b0;
      end else begin
         burst_active <= 1'b0;
         access_valid <= 1'b0;
         acc_first <= 1'b0;
      end
   end

   // ----------------------------------------
   // read latency pipe
   // ----------------------------------------
   logic acc_rd;
   logic rd_pipe;
   logic [COL_W-1:0] rd_pipe_col;
   assign acc_rd = access_valid && !access_write;

   // beat 0 reaches the data stage at edge n+m
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rd_pipe <= 1'b0;
         rd_pipe_col <= '0;
         dq_data_valid <= 1'b0;
         dq_col <= '0;
      end else begin
         rd_pipe <= acc_rd;
         rd_pipe_col <= access_col;
         dq_data_valid <= lat3 ? rd_pipe : acc_rd;
         dq_col <= lat3 ? rd_pipe_col : access_col;
      end
   end

   // drive one cycle ahead of valid data and hold through the last beat
   assign dq_drive_en = (lat3 ? rd_pipe : acc_rd) || dq_data_valid;

   // ----------------------------------------
   // register port
   // ----------------------------------------
   // unmapped addresses read zero; data only in the cycle after the strobe
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            REG_MODE: reg_rdata <= REG_DW'(mode);
            REG_BANKS: reg_rdata <= REG_DW'({burst_active, bank_open});
            REG_BURST: reg_rdata <= REG_DW'({access_bank, 7'h00, access_col});
            default: reg_rdata <= '0;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   chk_first_col: assert property (col_go |=> access_valid &&
         access_col == $past(cmd_addr[COL_W-1:0]))
      else $error("first beat not at start column");

   chk_block_wrap: assert property (access_valid && !acc_first |->
         (access_col & ~burst_mask) == (burst_start & ~burst_mask))
      else $error("beat left its column block");

   chk_seq_step: assert property (access_valid && !acc_first && !burst_il |->
         (access_col & burst_mask) == ((COL_W'($past(access_col) + 9'h001)) & burst_mask))
      else $error("sequential beat not one above previous");

   chk_single_write: assert property (col_go && col_wr && wr_single |=>
         access_valid ##1 (!access_valid || acc_first))
      else $error("single-access write ran longer than one beat");

   chk_burst_four: assert property ((col_go && bl_code == BL_CODE_4 &&
         !(col_wr && wr_single)) ##1 (!col_go)[*4] |=> !access_valid)
      else $error("burst of four did not stop after four beats");

   chk_latency_two: assert property (col_go && !col_wr && !lat3 ##1 !lat3
         |=> dq_data_valid)
      else $error("latency two data late");

   chk_latency_three: assert property (col_go && !col_wr && lat3 ##1 lat3 [*2]
         |=> dq_data_valid)
      else $error("latency three data late");

   chk_drive_lead: assert property ($rose(dq_data_valid) |-> $past(dq_drive_en))
      else $error("data valid without earlier drive");

   chk_row_open: assert property (col_go |=> access_row == bank_row[access_bank])
      else $error("access not on the activated row");

   chk_test_quiet: assert property (!mode_normal && !burst_active |=> !access_valid)
      else $error("column access outside normal mode");

endmodule : sdram_mode_burst_activate

// file: sdram_mode_burst_activate_test.sv
`timescale 1ns/1ps
module sdram_mode_burst_activate_test;
   import sdram_burst_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic clk_sys, resetn, cs_n, ras_n, cas_n, we_n, reg_wr, reg_rd;
   logic [BANK_W-1:0] bank_select_lines, access_bank;
   logic [ROW_W-1:0] addr, access_row;
   logic [REG_AW-1:0] reg_addr;
   logic [REG_DW-1:0] reg_wdata, reg_rdata, rd;
   logic access_valid, access_write, dq_drive_en, dq_data_valid, mode_normal;
   logic [COL_W-1:0] access_col, dq_col;
   logic [14:0] seen;
   logic [COL_W-1:0] av_col[$], dv_col[$];
   int av_c[$], dv_c[$];
   int err_total = 0, checked = 0, cyc = 0, de_c = -1;
   typedef struct {logic [2:0] bl; logic il; logic [2:0] lat; logic wr; logic wsa;
      logic [8:0] col; int n;} row_s;
   row_s rows [8] = '{'{3'h0, 1'h0, 3'h2, 1'h0, 1'h0, 9'h005, 1},
      '{3'h1, 1'h0, 3'h3, 1'h0, 1'h0, 9'h0ff, 2}, '{3'h2, 1'h0, 3'h2, 1'h0, 1'h0, 9'h021, 4},
      '{3'h2, 1'h1, 3'h3, 1'h0, 1'h0, 9'h021, 4}, '{3'h3, 1'h1, 3'h2, 1'h0, 1'h0, 9'h1fd, 8},
      '{3'h3, 1'h0, 3'h3, 1'h1, 1'h0, 9'h00b, 8}, '{3'h3, 1'h0, 3'h2, 1'h1, 1'h1, 9'h013, 1},
      '{3'h3, 1'h0, 3'h3, 1'h0, 1'h1, 9'h013, 8}};

   sdram_mode_burst_activate dut (.clk_sys, .resetn, .cs_n, .ras_n, .cas_n, .we_n,
      .bank_select_lines, .addr, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .access_valid, .access_write, .access_bank, .access_row, .access_col,
      .dq_drive_en, .dq_data_valid, .dq_col, .mode_normal);
   sdram_ctrl_model ctrl (.clk_sys, .cs_n, .ras_n, .cas_n, .we_n, .bank_select_lines, .addr);

   // clock
   initial begin
      clk_sys = 1'h0;
      forever #25 clk_sys = ~clk_sys;
   end

   // log beats; sampled before the edge updates land
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (access_valid) begin
         av_c.push_back(cyc);
         av_col.push_back(access_col);
         seen <= {access_write, access_bank, access_row};
      end
      if (dq_data_valid) begin
         dv_c.push_back(cyc);
         dv_col.push_back(dq_col);
      end
      if (dq_drive_en && de_c < 0) de_c = cyc;
   end

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic reg_read(input logic [REG_AW-1:0] a);
      @(posedge clk_sys);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'h0;
      #1 rd = reg_rdata;
   endtask : reg_read

   task automatic clear();
      av_c.delete();
      av_col.delete();
      dv_c.delete();
      dv_col.delete();
      de_c = -1;
   endtask : clear

   // expected column of beat i, worked out from block, start and order
   function automatic logic [8:0] ecol(input logic [8:0] s, input int len, input logic il,
      input int i);
      logic [8:0] msk;
      msk = 9'(len - 1);
      return (s & ~msk) | ((il ? (s ^ 9'(i)) : (s + 9'(i))) & msk);
   endfunction : ecol

   task automatic beats(input int n, input int len, input logic il, input logic [8:0] s,
      input int m, input logic rdq);
      repeat (len + 12) @(posedge clk_sys);
      #1 check(av_c.size(), n);
      for (int i = 0; i < av_col.size(); i++) begin
         check(av_col[i], ecol(s, len, il, i));
         check(av_c[i] - av_c[0], i);
         if (rdq && i < dv_col.size()) check(dv_col[i], ecol(s, len, il, i));
      end
      // writes must leave the data pins alone, reads give one data beat per access
      check(dv_c.size(), rdq ? n : 0);
      if (rdq && av_c.size() > 0 && dv_c.size() > 0) begin
         check(dv_c[0] - av_c[0], m - 1);
         check(de_c, dv_c[0] - 1);
      end
   endtask : beats

   task automatic summarize();
      $display("checked %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : summarize

   // watchdog well beyond the expected run
   initial begin
      repeat (5000) @(posedge clk_sys);
      err_total++;
      $display("Error %0t: watchdog expired", $time);
      summarize();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      logic [11:0] mode;
      resetn = 1'h0;
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'h1;
      foreach (rows[r]) begin
         mode = {2'h0, rows[r].wsa, 2'h0, rows[r].lat, rows[r].il, rows[r].bl};
         ctrl.issue(3'h0, 2'h0, mode);
         reg_read(REG_MODE);
         check(rd, {20'h0, mode});
         check(mode_normal, 1'h1);
         ctrl.issue(3'h3, 2'h2, 12'h5a3);
         reg_read(REG_BANKS);
         check(rd[4:0], 5'h04);
         clear();
         ctrl.issue(rows[r].wr ? 3'h4 : 3'h5, 2'h2, {3'h0, rows[r].col});
         beats(rows[r].n, 1 << rows[r].bl, rows[r].il, rows[r].col,
            rows[r].lat == 3'h2 ? 2 : 3, !rows[r].wr);
         check(seen, {rows[r].wr, 2'h2, 12'h5a3});
         // last beat's bank and column stay visible after the burst
         reg_read(REG_BURST);
         check(rd, {14'h0, 2'h2, 7'h00, ecol(rows[r].col, 1 << rows[r].bl, rows[r].il,
            rows[r].n - 1)});
         ctrl.issue(3'h2, 2'h0, 12'h400);
         $display("row %0d done", r);
      end
      // full page wraps at the page end, stopped by terminate
      ctrl.issue(3'h0, 2'h0, 12'h027);
      ctrl.issue(3'h3, 2'h1, 12'h0c4);
      clear();
      ctrl.issue(3'h5, 2'h1, 12'h1fe);
      repeat (2) @(posedge clk_sys);
      ctrl.issue(3'h6, 2'h1, 12'h000);
      repeat (12) @(posedge clk_sys);
      check(av_col.size(), 4);
      for (int i = 0; i < 4 && i < av_col.size(); i++) begin
         check(av_col[i], ecol(9'h1fe, 512, 1'h0, i));
      end
      ctrl.issue(3'h2, 2'h0, 12'h400);
      $display("full page done");
      // closed bank ignores column access; precharge needs the sync stages to land first
      @(posedge clk_sys);
      reg_read(REG_BANKS);
      check(rd[3:0], 4'h0);
      clear();
      ctrl.issue(3'h5, 2'h1, 12'h010);
      repeat (10) @(posedge clk_sys);
      check(av_c.size(), 0);
      // test mode ignores column access
      ctrl.issue(3'h0, 2'h0, 12'h082);
      check(mode_normal, 1'h0);
      ctrl.issue(3'h3, 2'h0, 12'h011);
      clear();
      ctrl.issue(3'h5, 2'h0, 12'h010);
      repeat (10) @(posedge clk_sys);
      check(av_c.size(), 0);
      ctrl.issue(3'h2, 2'h0, 12'h400);
      $display("refusals done");
      // register port: write back, unmapped read
      @(posedge clk_sys);
      reg_wr <= 1'h1;
      reg_addr <= REG_MODE;
      reg_wdata <= 32'h32;
      @(posedge clk_sys);
      reg_wr <= 1'h0;
      reg_read(REG_MODE);
      check(rd, 32'h32);
      reg_read(4'hc);
      check(rd, 32'h0);
      $display("register port done");
      // reset in mid-run clears mode and outputs
      @(posedge clk_sys);
      resetn <= 1'h0;
      @(posedge clk_sys);
      #1 check({mode_normal, access_valid, dq_drive_en, dq_data_valid}, 4'h8);
      check(reg_rdata, 32'h0);
      @(posedge clk_sys);
      resetn <= 1'h1;
      reg_read(REG_MODE);
      check(rd, 32'h0);
      $display("reset done");
      summarize();
   end
endmodule : sdram_mode_burst_activate_test
